// ### design/fscc_top.sv
`timescale 1ns/10ps
module fscc_top #(
  parameter int unsigned STALL_US = fscc_pkg::STALL_US_DEF
) (
  input  wire logic                      clk,
  input  wire logic                      srst,
  input  wire logic                      hsel,
  input  wire logic [31:0]               haddr,
  input  wire logic [1:0]                htrans,
  input  wire logic                      hwrite,
  input  wire logic [2:0]                hsize,
  input  wire logic [31:0]               hwdata,
  input  wire logic                      hready,
  output logic                           hreadyout,
  output logic                           hresp,
  output logic [31:0]                    hrdata,
  input  wire logic [fscc_pkg::NCH-1:0]  tach_in,
  output logic [fscc_pkg::NCH-1:0]       fan_pwm,
  output logic                           irq
);
  import fscc_pkg::*;

  logic                 act_w;
  logic                 wr_pend_q;
  logic [ADDR_W-1:0]    wr_addr_q;
  logic                 rd_pend_q;
  logic [ADDR_W-1:0]    rd_addr_q;
  logic                 hready_q;
  logic                 hresp_q;
  logic [31:0]          hrdata_q;
  logic [31:0]          rd_w;
  logic [CFG_W-1:0]     cfg_q      [NCH];
  logic [DUTY_W-1:0]    duty_set_q [NCH];
  logic [SPD_W-1:0]     tgt_q      [NCH];
  logic [DUTY_W-1:0]    duty_q     [NCH];
  logic [SPD_W-1:0]     speed_q    [NCH];
  fscc_st_t             st_q       [NCH];
  logic                 ev_stall_q [NCH];
  logic                 ev_at_q    [NCH];
  logic                 pwm_q      [NCH];
  logic [EV_TOT-1:0]    ris_q;
  logic [EV_TOT-1:0]    ien_q;
  logic [EV_TOT-1:0]    set_w;
  logic [EV_TOT-1:0]    clr_w;
  logic                 irq_q;
  logic [TICK_W-1:0]    tick_cnt_q;
  logic                 tick_q;
  logic [PWMD_W-1:0]    pwmd_q;
  logic [PWM_W-1:0]     pwm_cnt_q;

  function automatic logic ch_hit(input logic [ADDR_W-1:0] a, input int i);
    logic [ADDR_W-1:0] off;
    off = a - A_CH;
    return (a >= A_CH) && (int'(off >> CH_SHIFT) == i);
  endfunction

  assign hreadyout = hready_q;
  assign hresp     = hresp_q;
  assign hrdata    = hrdata_q;
  assign irq       = irq_q;

  assign act_w = hsel & htrans[HT_ACT] & hready & (hsize == HSIZE_WORD);

  // writes finish with no wait; reads take one wait state
  always_ff @(posedge clk) begin
    if (srst) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= '0;
      rd_pend_q <= 1'b0;
      rd_addr_q <= '0;
      hready_q  <= 1'b1;
      hresp_q   <= 1'b0;
      hrdata_q  <= '0;
    end else begin
      hresp_q   <= 1'b0;
      wr_pend_q <= act_w & hwrite;
      if (act_w & hwrite) begin
        wr_addr_q <= haddr[ADDR_W-1:0];
      end
      if (act_w & ~hwrite) begin
        rd_pend_q <= 1'b1;
        rd_addr_q <= haddr[ADDR_W-1:0];
        hready_q  <= 1'b0;
      end else if (rd_pend_q) begin
        rd_pend_q <= 1'b0;
        hready_q  <= 1'b1;
        hrdata_q  <= rd_w;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ien_q <= '0;
      for (int i = 0; i < NCH; i++) begin
        cfg_q[i]      <= '0;
        duty_set_q[i] <= DUTY_ZERO;
        tgt_q[i]      <= '0;
      end
    end else if (wr_pend_q) begin
      if (wr_addr_q == A_IEN) begin
        ien_q <= hwdata[EV_TOT-1:0];
      end
      for (int i = 0; i < NCH; i++) begin
        if (ch_hit(wr_addr_q, i)) begin
          case (wr_addr_q[3:2])
            R_CFG: begin
              cfg_q[i] <= hwdata[CFG_W-1:0];
            end
            R_DUTY: begin
              duty_set_q[i] <= (hwdata[DUTY_W-1:0] > DUTY_FULL) ? DUTY_FULL : hwdata[DUTY_W-1:0];
            end
            R_TGT: begin
              tgt_q[i] <= hwdata[SPD_W-1:0];
            end
            default: begin
            end
          endcase
        end
      end
    end
  end

  always_comb begin
    rd_w = '0;
    case (rd_addr_q)
      A_RIS:   rd_w[EV_TOT-1:0] = ris_q;
      A_MIS:   rd_w[EV_TOT-1:0] = ris_q & ien_q;
      A_IEN:   rd_w[EV_TOT-1:0] = ien_q;
      default: rd_w = '0;
    endcase
    for (int i = 0; i < NCH; i++) begin
      if (ch_hit(rd_addr_q, i)) begin
        case (rd_addr_q[3:2])
          R_CFG:   rd_w[CFG_W-1:0]  = cfg_q[i];
          R_DUTY:  rd_w[DUTY_W-1:0] = duty_q[i];
          R_TGT:   rd_w[SPD_W-1:0]  = tgt_q[i];
          R_SPD:   rd_w[SPD_W-1:0]  = speed_q[i];
          default: rd_w = '0;
        endcase
      end
    end
  end

  always_comb begin
    clr_w = '0;
    if (wr_pend_q && (wr_addr_q == A_ICLR)) begin
      clr_w = hwdata[EV_TOT-1:0];
    end
    for (int i = 0; i < NCH; i++) begin
      set_w[i*EV_N+EV_STALL] = ev_stall_q[i];
      set_w[i*EV_N+EV_AT]    = ev_at_q[i];
    end
  end

  // set beats a clear in the same cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      ris_q <= '0;
      irq_q <= 1'b0;
    end else begin
      ris_q <= (ris_q & ~clr_w) | set_w;
      irq_q <= |(ris_q & ien_q);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      tick_cnt_q <= '0;
      tick_q     <= 1'b0;
      pwmd_q     <= '0;
      pwm_cnt_q  <= '0;
    end else begin
      tick_q <= (tick_cnt_q == TICK_LAST);
      tick_cnt_q <= (tick_cnt_q == TICK_LAST) ? '0 : tick_cnt_q + 1'b1;
      pwmd_q <= (pwmd_q == PWMD_LAST) ? '0 : pwmd_q + 1'b1;
      if (pwmd_q == PWMD_LAST) begin
        pwm_cnt_q <= pwm_cnt_q + 1'b1;
      end
    end
  end

  for (genvar g = 0; g < NCH; g++) begin : g_ch
    logic                en_w;
    logic                auto_w;
    logic [1:0]          sd_w;
    logic [2:0]          se_w;
    logic [1:0]          hy_w;
    logic [1:0]          av_w;
    logic [1:0]          ppr_w;
    logic [2:0]          ts_q;
    logic                stab_q;
    logic                chg_w;
    logic                rise_w;
    logic [PER_W-1:0]    per_q;
    logic                valid_q;
    logic                stalled_q;
    logic                stall_w;
    logic                busy_q;
    logic [DIVC_W-1:0]   divc_q;
    logic [NUM_W-1:0]    num_q;
    logic [NUM_W-1:0]    quo_q;
    logic [DEN_W-1:0]    rem_q;
    logic [DEN_W-1:0]    den_q;
    logic [DEN_W:0]      rem2_w;
    logic                ge_w;
    logic [NUM_W-1:0]    quo_nx_w;
    logic [SPD_W-1:0]    samp_w;
    logic                done_w;
    logic [ACC_W-1:0]    acc_q;
    logic [ACC_W-1:0]    sum_w;
    logic [2:0]          acnt_q;
    logic                at_q;
    logic [SPD_W-1:0]    diff_w;
    logic [SE_W-1:0]     se_cnt_q;
    logic [2:0]          adj_q;
    logic [DUTY_W-1:0]   start_duty_w;
    logic [DUTY_W-1:0]   step_w;
    logic [DUTY_W:0]     up_w;

    assign en_w   = cfg_q[g][CFG_EN];
    assign auto_w = cfg_q[g][CFG_AUTO];
    assign sd_w   = cfg_q[g][CFG_SD+1:CFG_SD];
    assign se_w   = cfg_q[g][CFG_SE+2:CFG_SE];
    assign hy_w   = cfg_q[g][CFG_HY+1:CFG_HY];
    assign av_w   = cfg_q[g][CFG_AV+1:CFG_AV];
    assign ppr_w  = cfg_q[g][CFG_PPR+1:CFG_PPR];
    assign fan_pwm[g] = pwm_q[g];

    assign chg_w   = (ts_q[1] == ts_q[2]) && (ts_q[2] != stab_q);
    assign rise_w  = chg_w & ts_q[2];
    assign stall_w = en_w && tick_q && !stalled_q && !rise_w && (per_q == PER_W'(STALL_US - 1));

    always_ff @(posedge clk) begin
      // tach idles high on its pull-up; a low reset value would fake a rising edge
      if (srst) begin
        ts_q   <= '1;
        stab_q <= 1'b1;
      end else begin
        ts_q <= {ts_q[1:0], tach_in[g]};
        if (ts_q[1] == ts_q[2]) begin
          stab_q <= ts_q[2];
        end
      end
    end

    // interval timer in microseconds between rising tach edges
    always_ff @(posedge clk) begin
      if (srst || !en_w) begin
        per_q         <= '0;
        valid_q       <= 1'b0;
        stalled_q     <= 1'b0;
        ev_stall_q[g] <= 1'b0;
      end else begin
        ev_stall_q[g] <= stall_w;
        if (rise_w) begin
          per_q     <= '0;
          valid_q   <= 1'b1;
          stalled_q <= 1'b0;
        end else if (stall_w) begin
          stalled_q <= 1'b1;
          valid_q   <= 1'b0;
        end else if (tick_q && !stalled_q) begin
          per_q <= per_q + 1'b1;
        end
      end
    end

    always_comb begin
      rem2_w   = {rem_q, num_q[NUM_W-1]};
      ge_w     = rem2_w >= {1'b0, den_q};
      quo_nx_w = {quo_q[NUM_W-2:0], ge_w};
      samp_w   = (quo_nx_w > NUM_W'({SPD_W{1'b1}})) ? {SPD_W{1'b1}} : quo_nx_w[SPD_W-1:0];
      done_w   = busy_q && (divc_q == DIVC_LAST);
      sum_w    = acc_q + ACC_W'(samp_w);
    end

    // serial divide: rpm = minute in us / (interval * pulses per rev)
    always_ff @(posedge clk) begin
      if (srst || !en_w) begin
        busy_q <= 1'b0;
        divc_q <= '0;
        num_q  <= '0;
        quo_q  <= '0;
        rem_q  <= '0;
        den_q  <= '0;
      end else if (!busy_q) begin
        if (rise_w && valid_q && (per_q != '0)) begin
          busy_q <= 1'b1;
          divc_q <= '0;
          num_q  <= RPM_NUM;
          quo_q  <= '0;
          rem_q  <= '0;
          den_q  <= DEN_W'(per_q) * (DEN_W'(ppr_w) + DEN_W'(1));
        end
      end else begin
        num_q  <= {num_q[NUM_W-2:0], 1'b0};
        quo_q  <= quo_nx_w;
        rem_q  <= ge_w ? DEN_W'(rem2_w - {1'b0, den_q}) : rem2_w[DEN_W-1:0];
        divc_q <= divc_q + 1'b1;
        busy_q <= !done_w;
      end
    end

    always_ff @(posedge clk) begin
      if (srst || !en_w) begin
        acc_q      <= '0;
        acnt_q     <= '0;
        speed_q[g] <= '0;
      end else if (stall_w) begin
        acc_q      <= '0;
        acnt_q     <= '0;
        speed_q[g] <= '0;
      end else if (done_w) begin
        if (acnt_q == 3'((1 << av_w) - 1)) begin
          speed_q[g] <= SPD_W'(sum_w >> av_w);
          acc_q      <= '0;
          acnt_q     <= '0;
        end else begin
          acc_q  <= sum_w;
          acnt_q <= acnt_q + 1'b1;
        end
      end
    end

    assign diff_w = (speed_q[g] > tgt_q[g]) ? speed_q[g] - tgt_q[g] : tgt_q[g] - speed_q[g];

    always_ff @(posedge clk) begin
      if (srst || !en_w) begin
        at_q       <= 1'b0;
        ev_at_q[g] <= 1'b0;
      end else begin
        at_q       <= auto_w && (st_q[g] == ST_RUN) && (speed_q[g] != '0) && (diff_w <= AT_TOL);
        ev_at_q[g] <= auto_w && (st_q[g] == ST_RUN) && (speed_q[g] != '0) && (diff_w <= AT_TOL) && !at_q;
      end
    end

    always_comb begin
      case (sd_w)
        2'h1:    start_duty_w = DUTY_50;
        2'h2:    start_duty_w = DUTY_75;
        2'h3:    start_duty_w = DUTY_FULL;
        default: start_duty_w = DUTY_ZERO;
      endcase
      step_w = cfg_q[g][CFG_FAST] ? STEP_FAST : STEP_SLOW;
      up_w   = {1'b0, duty_q[g]} + {1'b0, step_w};
    end

    // channel sequencing and duty control
    always_ff @(posedge clk) begin
      if (srst || !en_w) begin
        st_q[g]   <= ST_OFF;
        duty_q[g] <= DUTY_ZERO;
        se_cnt_q  <= '0;
        adj_q     <= '0;
      end else begin
        case (st_q[g])
          ST_OFF: begin
            se_cnt_q <= '0;
            adj_q    <= '0;
            if (auto_w && (sd_w != 2'h0)) begin
              st_q[g]   <= ST_START;
              duty_q[g] <= start_duty_w;
            end else begin
              st_q[g] <= ST_RUN;
            end
          end
          ST_START: begin
            duty_q[g] <= start_duty_w;
            if (!auto_w) begin
              st_q[g] <= ST_RUN;
            end else if (stall_w) begin
              se_cnt_q <= '0;
              if (cfg_q[g][CFG_NORST]) begin
                st_q[g] <= ST_HALT;
              end
            end else if (chg_w) begin
              se_cnt_q <= se_cnt_q + 1'b1;
              if (se_cnt_q == SE_W'((START_EDGE_MIN << se_w) - 1)) begin
                st_q[g] <= ST_RUN;
                adj_q   <= '0;
              end
            end
          end
          ST_RUN: begin
            if (!auto_w) begin
              duty_q[g] <= duty_set_q[g];
            end else if (stall_w) begin
              se_cnt_q <= '0;
              if (cfg_q[g][CFG_NORST]) begin
                st_q[g] <= ST_HALT;
              end else if (sd_w != 2'h0) begin
                st_q[g]   <= ST_START;
                duty_q[g] <= start_duty_w;
              end
            end else if (rise_w) begin
              adj_q <= adj_q + 1'b1;
              if (adj_q == 3'((1 << hy_w) - 1)) begin
                adj_q <= '0;
                if (speed_q[g] < tgt_q[g]) begin
                  duty_q[g] <= (up_w > {1'b0, DUTY_FULL}) ? DUTY_FULL : up_w[DUTY_W-1:0];
                end else if (speed_q[g] > tgt_q[g]) begin
                  duty_q[g] <= (duty_q[g] > step_w) ? duty_q[g] - step_w : DUTY_ZERO;
                end
              end
            end
          end
          ST_HALT: begin
            duty_q[g] <= DUTY_ZERO;
            if (!auto_w) begin
              st_q[g] <= ST_RUN;
            end
          end
          default: begin
            st_q[g] <= ST_OFF;
          end
        endcase
      end
    end

    always_ff @(posedge clk) begin
      if (srst || !en_w) begin
        pwm_q[g] <= 1'b0;
      end else begin
        pwm_q[g] <= (st_q[g] != ST_OFF) && ({1'b0, pwm_cnt_q} < duty_q[g]);
      end
    end
  end

endmodule

// ### pkg/fscc_pkg.sv
package fscc_pkg;

  localparam int NCH        = 2;
  localparam int CLK_HZ     = 200_000_000;
  localparam int US_PER_S   = 1_000_000;
  localparam int S_PER_MIN  = 60;
  localparam int TICK_CYC   = CLK_HZ / US_PER_S;
  localparam int TICK_W     = 8;
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYC - 1);

  localparam int STALL_US_DEF = 250_000;

  localparam int PWM_W      = 10;
  localparam int PWM_DIV    = 8;
  localparam int PWMD_W     = 3;
  localparam logic [PWMD_W-1:0] PWMD_LAST = PWMD_W'(PWM_DIV - 1);

  localparam int DUTY_W     = 11;
  localparam logic [DUTY_W-1:0] DUTY_FULL = 11'h400;
  localparam logic [DUTY_W-1:0] DUTY_75   = 11'h300;
  localparam logic [DUTY_W-1:0] DUTY_50   = 11'h200;
  localparam logic [DUTY_W-1:0] DUTY_ZERO = 11'h000;
  localparam logic [DUTY_W-1:0] STEP_FAST = 11'h010;
  localparam logic [DUTY_W-1:0] STEP_SLOW = 11'h001;

  localparam int PER_W      = 20;
  localparam int SPD_W      = 16;
  localparam int DEN_W      = 23;
  localparam int NUM_W      = 26;
  localparam int ACC_W      = SPD_W + 3;
  localparam int DIVC_W     = 5;
  localparam logic [NUM_W-1:0] RPM_NUM = NUM_W'(S_PER_MIN * US_PER_S);
  localparam logic [DIVC_W-1:0] DIVC_LAST = DIVC_W'(NUM_W - 1);
  localparam logic [SPD_W-1:0] AT_TOL  = 16'h0020;

  localparam int SE_W       = 9;
  localparam int START_EDGE_MIN = 2;

  localparam int ADDR_W     = 8;
  localparam logic [ADDR_W-1:0] A_RIS   = 8'h00;
  localparam logic [ADDR_W-1:0] A_MIS   = 8'h04;
  localparam logic [ADDR_W-1:0] A_IEN   = 8'h08;
  localparam logic [ADDR_W-1:0] A_ICLR  = 8'h0c;
  localparam logic [ADDR_W-1:0] A_CH    = 8'h10;
  localparam int CH_SHIFT   = 4;
  localparam logic [1:0] R_CFG  = 2'h0;
  localparam logic [1:0] R_DUTY = 2'h1;
  localparam logic [1:0] R_TGT  = 2'h2;
  localparam logic [1:0] R_SPD  = 2'h3;
  localparam int HT_ACT     = 1;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  localparam int CFG_W      = 15;
  localparam int CFG_EN     = 0;
  localparam int CFG_AUTO   = 1;
  localparam int CFG_NORST  = 2;
  localparam int CFG_FAST   = 3;
  localparam int CFG_SD     = 4;
  localparam int CFG_SE     = 6;
  localparam int CFG_HY     = 9;
  localparam int CFG_AV     = 11;
  localparam int CFG_PPR    = 13;

  localparam int EV_STALL   = 0;
  localparam int EV_AT      = 1;
  localparam int EV_N       = 2;
  localparam int EV_TOT     = EV_N * NCH;

  typedef enum logic [1:0] {
    ST_OFF   = 2'b00,
    ST_START = 2'b01,
    ST_RUN   = 2'b10,
    ST_HALT  = 2'b11
  } fscc_st_t;

endpackage

// ### verif/fscc_chk.sv
`timescale 1ns/10ps
module fscc_chk #(
  parameter int unsigned STALL_US = 50
) (
  input wire logic                     clk,
  input wire logic                     srst,
  input wire logic                     hsel,
  input wire logic [31:0]              haddr,
  input wire logic [1:0]               htrans,
  input wire logic                     hwrite,
  input wire logic [2:0]               hsize,
  input wire logic [31:0]              hwdata,
  input wire logic                     hready,
  input wire logic                     hreadyout,
  input wire logic                     hresp,
  input wire logic [31:0]              hrdata,
  input wire logic [fscc_pkg::NCH-1:0] tach_in,
  input wire logic [fscc_pkg::NCH-1:0] fan_pwm,
  input wire logic                     irq
);
  import fscc_pkg::*;
  logic       take;
  logic       wr_v_q;
  logic [7:0] wr_a_q;
  logic [3:0] ien_sh_q;

  assign take = hsel && htrans[HT_ACT] && hready && (hsize == HSIZE_WORD);

  always_ff @(posedge clk) begin
    if (srst) begin
      wr_v_q <= 1'b0;
      wr_a_q <= 8'h00;
    end else begin
      wr_v_q <= take && hwrite;
      wr_a_q <= haddr[7:0];
    end
  end

  // shadow of the enable register, for the interrupt mask check
  always_ff @(posedge clk) begin
    if (srst) begin
      ien_sh_q <= 4'h0;
    end else if (wr_v_q && (wr_a_q == A_IEN)) begin
      ien_sh_q <= hwdata[3:0];
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  resp_okay_a: assert property (hresp == 1'b0)
    else $error("slave response not okay");
  rd_wait_a: assert property (take && !hwrite |=> !hreadyout)
    else $error("read without wait cycle");
  rd_wait_one_a: assert property (!hreadyout |=> hreadyout)
    else $error("read wait longer than one cycle");
  wait_cause_a: assert property (!hreadyout |-> $past(take && !hwrite))
    else $error("wait cycle without a read");
  wr_nowait_a: assert property (take && hwrite |=> hreadyout)
    else $error("write inserted a wait cycle");
  rdata_hold_a: assert property (!$stable(hrdata) |-> !$past(hreadyout))
    else $error("read data changed outside a read");
  irq_mask_a: assert property ((ien_sh_q == 4'h0) [*3] |-> !irq)
    else $error("interrupt raised while all sources masked");
  chan_off_a: assert property (wr_v_q && wr_a_q == A_CH && !hwdata[CFG_EN] |-> ##3 (!fan_pwm[0]) [*2])
    else $error("pwm still driven after channel disable");
  rst_quiet_a: assert property ($fell(srst) |-> hreadyout && !irq && fan_pwm == '0 && hrdata == 32'h0)
    else $error("outputs not at reset values");
endmodule

// ### verif/fscc_fan_model.sv
`timescale 1ns/10ps
module fscc_fan_model (
  input  wire logic        pwm,
  input  wire logic        run,
  input  wire logic [15:0] half_ns,
  output logic             tach
);
  realtime last_hi;

  // rotor coasts about one pwm period after drive is lost, then stops
  always @(negedge pwm) begin
    last_hi = $realtime;
  end

  // open-collector tach: pulled high while the rotor stands still
  initial begin
    last_hi = -1.0e6;
    tach = 1'b1;
    forever begin
      #((half_ns == 16'h0) ? 1000 : half_ns);
      if (run && (pwm || ($realtime - last_hi) < 41000.0)) begin
        tach = ~tach;
      end else begin
        tach = 1'b1;
      end
    end
  end
endmodule

// ### verif/tb_cooling_fan_speed_controller.sv
`timescale 1ns/10ps
module tb_cooling_fan_speed_controller;
  import fscc_pkg::*;
  localparam int STALL_T = 50;
  localparam int CYC_US  = 200;
  localparam int PER_CYC = (1 << PWM_W) * PWM_DIV;
  logic              clk;
  logic              srst;
  logic              hsel;
  logic              hwrite;
  logic [1:0]        htrans;
  logic [2:0]        hsize;
  logic [31:0]       haddr;
  logic [31:0]       hwdata;
  logic              hreadyout;
  logic              hresp;
  logic [31:0]       hrdata;
  logic              irq;
  logic [NCH-1:0]    tach_in;
  logic [NCH-1:0]    fan_pwm;
  logic [NCH-1:0]    run;
  logic [15:0]       half_ns [NCH];
  logic [31:0]       rng;
  logic [31:0]       rd;
  logic [DUTY_W-1:0] dw;
  logic [DUTY_W-1:0] dexp [NCH];
  logic [DUTY_W-1:0] sd_tab [4];
  int                cnt [NCH];
  int                fail_count;
  int                n_checks;
  int                cyc;

  fscc_top #(.STALL_US(STALL_T)) dut (.clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .tach_in(tach_in), .fan_pwm(fan_pwm), .irq(irq));
  fscc_fan_model fan0 (.pwm(fan_pwm[0]), .run(run[0]), .half_ns(half_ns[0]), .tach(tach_in[0]));
  fscc_fan_model fan1 (.pwm(fan_pwm[1]), .run(run[1]), .half_ns(half_ns[1]), .tach(tach_in[1]));

  always #2.5 clk = ~clk;

  task end_sim;
    if (fail_count == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 99000) begin
      fail_count++;
      end_sim();
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  function automatic logic [7:0] ra(input int ch, input logic [1:0] r);
    return A_CH + 8'(ch << CH_SHIFT) + {4'h0, r, 2'b00};
  endfunction

  function automatic logic [31:0] rpm(input int iv_us, input int ppr);
    int v;
    v = 60_000_000 / (iv_us * ppr);
    return (v > 65535) ? 32'h0000ffff : 32'(v);
  endfunction

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h0, a};
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    q = hrdata;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d, rd);
  endtask

  task rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0, rd);
    chk(nm, e, rd);
  endtask

  // restart a channel cleanly: disable, let pwm settle, then apply the new setup
  task cfg0(input logic [31:0] v);
    wr(ra(0, R_CFG), 32'h0);
    repeat (8) @(posedge clk);
    wr(ra(0, R_CFG), v);
  endtask

  initial begin
    clk = 1'b0;
    srst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = HSIZE_WORD;
    hwdata = 32'h0;
    run = '1;
    half_ns[0] = 16'd1500;
    half_ns[1] = 16'd2500;
    rng = 32'd61;
    sd_tab = '{DUTY_ZERO, DUTY_50, DUTY_75, DUTY_FULL};
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    for (int a = 0; a < 'h30; a += 4) rdchk("reset_value", 8'(a), 32'h0);
    hsize <= 3'h0;
    wr(A_IEN, 32'hf);
    hsize <= HSIZE_WORD;
    rdchk("size_ignored", A_IEN, 32'h0);
    wr(8'h80, 32'hffffffff);
    rdchk("unmapped", 8'h80, 32'h0);
    wr(ra(0, R_CFG), 32'h1 | (1 << CFG_AV) | (1 << CFG_PPR));
    wr(ra(1, R_CFG), 32'h1);
    for (int i = 0; i < 2; i++) begin
      for (int c = 0; c < NCH; c++) begin
        rng = xs(rng);
        dw = (i == 1) ? ((c == 0) ? 11'h7ff : 11'h000) : {1'b0, rng[9:0]};
        dexp[c] = (dw > DUTY_FULL) ? DUTY_FULL : dw;
        wr(ra(c, R_DUTY), {21'h0, dw});
        rdchk("duty_readback", ra(c, R_DUTY), {21'h0, dexp[c]});
      end
      repeat (PER_CYC) @(posedge clk);
      cnt = '{0, 0};
      repeat (PER_CYC) begin
        @(posedge clk);
        for (int c = 0; c < NCH; c++) if (fan_pwm[c] === 1'b1) cnt[c]++;
      end
      for (int c = 0; c < NCH; c++) chk("pwm_high", 32'(dexp[c]) * PWM_DIV, 32'(cnt[c]));
    end
    rdchk("speed", ra(0, R_SPD), rpm(3, 2));
    wr(ra(1, R_CFG), 32'h0);
    rdchk("duty_off", ra(1, R_DUTY), 32'h0);
    repeat (8) @(posedge clk);
    chk("pwm_off", 32'h0, {31'h0, fan_pwm[1]});
    wr(A_IEN, 32'h1);
    wr(A_ICLR, 32'hf);
    run[0] <= 1'b0;
    repeat (44 * CYC_US) @(posedge clk);
    rdchk("stall_early", A_RIS, 32'h0);
    repeat (12 * CYC_US) @(posedge clk);
    rdchk("stall_flag", A_RIS, 32'h1);
    rdchk("masked", A_MIS, 32'h1);
    rdchk("speed_stall", ra(0, R_SPD), 32'h0);
    chk("irq_on", 32'h1, {31'h0, irq});
    wr(A_IEN, 32'h0);
    repeat (2) @(posedge clk);
    chk("irq_masked", 32'h0, {31'h0, irq});
    rdchk("masked_off", A_MIS, 32'h0);
    wr(A_IEN, 32'h1);
    repeat (2) @(posedge clk);
    chk("irq_again", 32'h1, {31'h0, irq});
    wr(A_ICLR, 32'h1);
    repeat (2) @(posedge clk);
    chk("irq_clear", 32'h0, {31'h0, irq});
    rdchk("raw_clear", A_RIS, 32'h0);
    run[0] <= 1'b1;
    for (int s = 1; s < 4; s++) begin
      cfg0(32'h3 | (s << CFG_SD) | (7 << CFG_SE));
      rdchk("start_duty", ra(0, R_DUTY), {21'h0, sd_tab[s]});
    end
    cfg0(32'h3 | (1 << CFG_FAST) | (3 << CFG_SD));
    wr(ra(0, R_TGT), 32'h100);
    repeat (8) @(posedge tach_in[0]);
    ahb(1'b0, ra(0, R_DUTY), 32'h0, rd);
    chk("fast_ramp", 32'h1, {31'h0, rd >= 32'h380 && rd <= 32'h3f0 && rd[3:0] == 4'h0});
    cfg0(32'h3 | (3 << CFG_SD) | (2 << CFG_HY));
    wr(ra(0, R_TGT), 32'h100);
    repeat (10) @(posedge tach_in[0]);
    ahb(1'b0, ra(0, R_DUTY), 32'h0, rd);
    chk("slow_ramp", 32'h1, {31'h0, rd >= 32'h3fc && rd <= 32'h3ff});
    wr(A_ICLR, 32'hf);
    wr(ra(0, R_TGT), 32'hffff);
    repeat (4) @(posedge clk);
    rdchk("at_speed", A_RIS, 32'h2);
    for (int m = 0; m < 2; m++) begin
      cfg0(32'h3 | (m << CFG_NORST) | (3 << CFG_SD) | (3 << CFG_HY));
      repeat (6) @(posedge tach_in[0]);
      run[0] <= 1'b0;
      repeat (56 * CYC_US) @(posedge clk);
      rdchk("stall_duty", ra(0, R_DUTY), (m == 1) ? 32'h0 : 32'h400);
      run[0] <= 1'b1;
      repeat (10 * CYC_US) @(posedge clk);
      rdchk("after_stall", ra(0, R_DUTY), (m == 1) ? 32'h0 : 32'h400);
    end
    end_sim();
  end
endmodule

bind fscc_top fscc_chk #(.STALL_US(STALL_US)) u_chk (.clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .hrdata(hrdata), .tach_in(tach_in), .fan_pwm(fan_pwm), .irq(irq));
